// ==== otfac_defs.vh ====
// Offsets, field positions, reset values and cycle counts of the fuse access controller.
`ifndef OTFAC_DEFS_VH
`define OTFAC_DEFS_VH

// Register offsets.
`define OTFAC_OFS_CTL      8'h00
`define OTFAC_OFS_ADDR     8'h04
`define OTFAC_OFS_DATA     8'h08
`define OTFAC_OFS_SUPPLY   8'h10
`define OTFAC_OFS_CMD      8'h18
`define OTFAC_OFS_TRIG     8'h1C
`define OTFAC_OFS_PTIM1    8'h20
`define OTFAC_OFS_PTIM2    8'h24
`define OTFAC_OFS_PTIM3    8'h28
`define OTFAC_OFS_RTIM4    8'h2C
`define OTFAC_OFS_RTIM5    8'h30

// Reset values.
`define OTFAC_RST_CTL      12'h000
`define OTFAC_RST_SUPPLY   2'h1
`define OTFAC_RST_CMD      2'h2
`define OTFAC_RST_PTIM1    27'h010_4E06
`define OTFAC_RST_PTIM2    27'h09C_0884
`define OTFAC_RST_PTIM3    18'h0_0C27
`define OTFAC_RST_RTIM4    27'h030_180F
`define OTFAC_RST_RTIM5    27'h03C_100C

// Control bit positions.
`define OTFAC_CTL_HOLD_SEL   11
`define OTFAC_CTL_DSU_SEL    10
`define OTFAC_CTL_RSU_SEL    9
`define OTFAC_CTL_STB_SEL    8
`define OTFAC_CTL_HREL_SEL   7
`define OTFAC_CTL_AEN_SEL    6
`define OTFAC_CTL_DHLD_SEL   5
`define OTFAC_CTL_ZONE_LSB   1
`define OTFAC_CTL_EN         0
`define OTFAC_CTL_WIDTH      12

// Supply, trigger and command encodings.
`define OTFAC_SUP_PROG     1
`define OTFAC_SUP_LOGIC    0
`define OTFAC_TRIG_BIT     1
`define OTFAC_CMD_READ     2'h0
`define OTFAC_CMD_PROG     2'h1
`define OTFAC_CMD_IDLE     2'h2

// Fixed cycle counts.
`define OTFAC_FIX_HOLD     9'h006
`define OTFAC_FIX_DSU      9'h00F
`define OTFAC_FIX_RSU      9'h00C
`define OTFAC_FIX_STB      9'h00C
`define OTFAC_FIX_HREL     9'h00C
`define OTFAC_FIX_AEN      9'h008
`define OTFAC_FIX_DHLD     9'h00F

`endif

// ==== otfac_timer.v ====
// Down counter that times one phase of a fuse access sequence.
`timescale 1ns/1ps
module otfac_timer #(
  parameter CW = 9
) (
  // Clock and reset.
  input  wire          clk,
  input  wire          resetn,
  // Phase control.
  input  wire          start,
  input  wire [CW-1:0] load_val,
  output wire          done
);

  reg [CW-1:0] cnt_r;

  // A zero load still lasts one cycle.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= {CW{1'b0}};
    else if (start)
      cnt_r <= (load_val == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : load_val;
    else if (cnt_r != {CW{1'b0}})
      cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
  end

  assign done = (cnt_r == {{(CW-1){1'b0}}, 1'b1});

endmodule // otfac_timer

// ==== otfac_ctrl.v ====
// Fuse access controller: register file, read and program sequencer.
`timescale 1ns/1ps
`include "otfac_defs.vh"
module otfac_ctrl #(
  parameter AW = 8,
  parameter TW = 9
) (
  // Clock and reset.
  input  wire          clk,
  input  wire          resetn,
  // Host register port.
  input  wire          reg_sel,
  input  wire          reg_wr,
  input  wire [7:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  output reg  [31:0]   reg_rdata,
  input  wire          reg_unlock,
  // Fuse array macro.
  output reg  [AW-1:0] fuse_addr,
  output reg  [2:0]    fuse_bit,
  output reg           fuse_rd_en,
  output reg           fuse_strobe,
  output reg           fuse_pgm_en,
  output reg           fuse_pgm_pulse,
  input  wire [7:0]    fuse_rdata,
  // Supplies and status.
  output wire          logic_supply_en,
  output wire          prog_supply_en,
  output wire          busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_R_DSU = 4'h1;
  localparam [3:0] ST_R_ASU = 4'h2;
  localparam [3:0] ST_R_AEN = 4'h3;
  localparam [3:0] ST_R_SU  = 4'h4;
  localparam [3:0] ST_R_STB = 4'h5;
  localparam [3:0] ST_R_REL = 4'h6;
  localparam [3:0] ST_R_HLD = 4'h7;
  localparam [3:0] ST_R_DHD = 4'h8;
  localparam [3:0] ST_P_SUP = 4'h9;
  localparam [3:0] ST_P_SET = 4'hA;
  localparam [3:0] ST_P_AEN = 4'hB;
  localparam [3:0] ST_P_PUL = 4'hC;
  localparam [3:0] ST_P_HLD = 4'hD;
  localparam [3:0] ST_P_SUH = 4'hE;
  localparam [3:0] ST_P_SCN = 4'hF;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  reg [`OTFAC_CTL_WIDTH-1:0] ctl_r;
  reg [AW-1:0]               addr_r;
  reg [7:0]                  data_r;
  reg [1:0]                  supply_r;
  reg [1:0]                  cmd_r;
  reg                        trig_r;
  reg [26:0]                 ptim1_r;
  reg [26:0]                 ptim2_r;
  reg [17:0]                 ptim3_r;
  reg [26:0]                 rtim4_r;
  reg [26:0]                 rtim5_r;
  reg [3:0]                  st_r;
  reg [3:0]                  st_nxt;
  reg [3:0]                  bit_r;
  reg [3:0]                  bit_nxt;
  reg [TW-1:0]               dur;
  reg                        zone_ok;
  reg                        finish;

  wire wr_en    = reg_sel & reg_wr;
  wire rd_en    = reg_sel & ~reg_wr;
  wire wr_prot  = wr_en & reg_unlock;
  wire tmr_done;
  wire tmr_start;
  wire capture;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase lengths picked by the control bits.
  wire [TW-1:0] t_hold = ctl_r[`OTFAC_CTL_HOLD_SEL] ? ptim3_r[17:9]    : `OTFAC_FIX_HOLD;
  wire [TW-1:0] t_dsu  = ctl_r[`OTFAC_CTL_DSU_SEL]  ? rtim4_r[8:0]     : `OTFAC_FIX_DSU;
  wire [TW-1:0] t_rsu  = ctl_r[`OTFAC_CTL_RSU_SEL]  ? rtim4_r[17:9]    : `OTFAC_FIX_RSU;
  wire [TW-1:0] t_stb  = ctl_r[`OTFAC_CTL_STB_SEL]  ? rtim4_r[26:18]   : `OTFAC_FIX_STB;
  wire [TW-1:0] t_rel  = ctl_r[`OTFAC_CTL_HREL_SEL] ? rtim5_r[8:0]     : `OTFAC_FIX_HREL;
  wire [TW-1:0] t_aen  = ctl_r[`OTFAC_CTL_AEN_SEL]  ? rtim5_r[17:9]    : `OTFAC_FIX_AEN;
  wire [TW-1:0] t_dhd  = ctl_r[`OTFAC_CTL_DHLD_SEL] ? rtim5_r[26:18]   : `OTFAC_FIX_DHLD;

  ////////////////////////////////////////////////////////////////////////////////
  // Zone check on the top two address bits.
  always @*
  begin
    zone_ok = ctl_r[`OTFAC_CTL_ZONE_LSB + addr_r[AW-1:AW-2]];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the sequencer.
  always @*
  begin
    st_nxt  = st_r;
    bit_nxt = bit_r;
    finish  = 1'b0;
    case (st_r)
      ST_IDLE:
      begin
        bit_nxt = 4'h0;
        if (trig_r)
        begin
          if (!ctl_r[`OTFAC_CTL_EN] || !zone_ok)
            finish = 1'b1;
          else if (cmd_r == `OTFAC_CMD_READ)
            st_nxt = ST_R_DSU;
          else if (cmd_r == `OTFAC_CMD_PROG)
            st_nxt = ST_P_SUP;
          else
            finish = 1'b1;
        end
      end
      ST_R_DSU: if (tmr_done) st_nxt = ST_R_ASU;
      ST_R_ASU: if (tmr_done) st_nxt = ST_R_AEN;
      ST_R_AEN: if (tmr_done) st_nxt = ST_R_SU;
      ST_R_SU:  if (tmr_done) st_nxt = ST_R_STB;
      ST_R_STB: if (tmr_done) st_nxt = ST_R_REL;
      ST_R_REL: if (tmr_done) st_nxt = ST_R_HLD;
      ST_R_HLD: if (tmr_done) st_nxt = ST_R_DHD;
      ST_R_DHD:
      begin
        if (tmr_done)
        begin
          st_nxt = ST_IDLE;
          finish = 1'b1;
        end
      end
      ST_P_SUP: if (tmr_done) st_nxt = ST_P_SCN;
      ST_P_SCN:
      begin
        if (bit_r[3])
          st_nxt = ST_P_SUH;
        else if (data_r[bit_r[2:0]])
          st_nxt = ST_P_SET;
        else
          bit_nxt = bit_r + 4'h1;
      end
      ST_P_SET: if (tmr_done) st_nxt = ST_P_AEN;
      ST_P_AEN: if (tmr_done) st_nxt = ST_P_PUL;
      ST_P_PUL: if (tmr_done) st_nxt = ST_P_HLD;
      ST_P_HLD:
      begin
        if (tmr_done)
        begin
          st_nxt  = ST_P_SCN;
          bit_nxt = bit_r + 4'h1;
        end
      end
      ST_P_SUH:
      begin
        if (tmr_done)
        begin
          st_nxt = ST_IDLE;
          finish = 1'b1;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Length of the phase being entered.
  always @*
  begin
    case (st_nxt)
      ST_R_DSU: dur = t_dsu;
      ST_R_ASU: dur = ptim1_r[8:0];
      ST_R_AEN: dur = t_aen;
      ST_R_SU:  dur = t_rsu;
      ST_R_STB: dur = t_stb;
      ST_R_REL: dur = t_rel;
      ST_R_HLD: dur = t_hold;
      ST_R_DHD: dur = t_dhd;
      ST_P_SUP: dur = ptim1_r[17:9];
      ST_P_SET: dur = ptim1_r[26:18];
      ST_P_AEN: dur = ptim2_r[26:18];
      ST_P_PUL: dur = ptim2_r[8:0];
      ST_P_HLD: dur = ptim2_r[17:9];
      ST_P_SUH: dur = ptim3_r[8:0];
      default:  dur = {TW{1'b0}};
    endcase
  end

  assign tmr_start = (st_nxt != st_r) && (st_nxt != ST_IDLE) && (st_nxt != ST_P_SCN);
  assign capture   = (st_r == ST_R_STB) && tmr_done;

  otfac_timer #(
    .CW       (TW)
  ) u_timer (
    .clk      (clk),
    .resetn   (resetn),
    .start    (tmr_start),
    .load_val (dur),
    .done     (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state and fuse macro pins.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r           <= ST_IDLE;
      bit_r          <= 4'h0;
      fuse_addr      <= {AW{1'b0}};
      fuse_bit       <= 3'h0;
      fuse_rd_en     <= 1'b0;
      fuse_strobe    <= 1'b0;
      fuse_pgm_en    <= 1'b0;
      fuse_pgm_pulse <= 1'b0;
    end
    else
    begin
      st_r           <= st_nxt;
      bit_r          <= bit_nxt;
      fuse_bit       <= bit_nxt[2:0];
      if (st_r == ST_IDLE)
        fuse_addr    <= addr_r;
      fuse_rd_en     <= (st_nxt >= ST_R_AEN) && (st_nxt <= ST_R_REL);
      fuse_strobe    <= (st_nxt == ST_R_STB);
      fuse_pgm_en    <= (st_nxt >= ST_P_AEN) && (st_nxt <= ST_P_HLD);
      fuse_pgm_pulse <= (st_nxt == ST_P_PUL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl_r    <= `OTFAC_RST_CTL;
      addr_r   <= {AW{1'b0}};
      data_r   <= 8'h00;
      supply_r <= `OTFAC_RST_SUPPLY;
      cmd_r    <= `OTFAC_RST_CMD;
      trig_r   <= 1'b0;
      ptim1_r  <= `OTFAC_RST_PTIM1;
      ptim2_r  <= `OTFAC_RST_PTIM2;
      ptim3_r  <= `OTFAC_RST_PTIM3;
      rtim4_r  <= `OTFAC_RST_RTIM4;
      rtim5_r  <= `OTFAC_RST_RTIM5;
    end
    else
    begin
      if (wr_prot && reg_addr == `OTFAC_OFS_CTL && !trig_r)
        ctl_r <= reg_wdata[`OTFAC_CTL_WIDTH-1:0];
      if (wr_en && reg_addr == `OTFAC_OFS_ADDR && !trig_r)
        addr_r <= reg_wdata[AW-1:0];
      if (capture)
        data_r <= fuse_rdata;
      else if (wr_en && reg_addr == `OTFAC_OFS_DATA && !trig_r)
        data_r <= reg_wdata[7:0];
      if (wr_en && reg_addr == `OTFAC_OFS_SUPPLY)
        supply_r <= reg_wdata[1:0];
      if (wr_en && reg_addr == `OTFAC_OFS_CMD && !trig_r)
        cmd_r <= reg_wdata[1:0];
      if (finish)
        trig_r <= 1'b0;
      else if (wr_prot && reg_addr == `OTFAC_OFS_TRIG && !trig_r)
        trig_r <= reg_wdata[`OTFAC_TRIG_BIT];
      if (wr_en && reg_addr == `OTFAC_OFS_PTIM1 && !trig_r)
        ptim1_r <= reg_wdata[26:0];
      if (wr_en && reg_addr == `OTFAC_OFS_PTIM2 && !trig_r)
        ptim2_r <= reg_wdata[26:0];
      if (wr_en && reg_addr == `OTFAC_OFS_PTIM3 && !trig_r)
        ptim3_r <= reg_wdata[17:0];
      if (wr_en && reg_addr == `OTFAC_OFS_RTIM4 && !trig_r)
        rtim4_r <= reg_wdata[26:0];
      if (wr_en && reg_addr == `OTFAC_OFS_RTIM5 && !trig_r)
        rtim5_r <= reg_wdata[26:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the request.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (reg_addr)
        `OTFAC_OFS_CTL:    reg_rdata <= {20'h0_0000, ctl_r};
        `OTFAC_OFS_ADDR:   reg_rdata <= {{(32-AW){1'b0}}, addr_r};
        `OTFAC_OFS_DATA:   reg_rdata <= {24'h00_0000, data_r};
        `OTFAC_OFS_SUPPLY: reg_rdata <= {30'h0000_0000, supply_r};
        `OTFAC_OFS_CMD:    reg_rdata <= {30'h0000_0000, cmd_r};
        `OTFAC_OFS_TRIG:   reg_rdata <= {30'h0000_0000, trig_r, 1'b0};
        `OTFAC_OFS_PTIM1:  reg_rdata <= {5'h00, ptim1_r};
        `OTFAC_OFS_PTIM2:  reg_rdata <= {5'h00, ptim2_r};
        `OTFAC_OFS_PTIM3:  reg_rdata <= {14'h0000, ptim3_r};
        `OTFAC_OFS_RTIM4:  reg_rdata <= {5'h00, rtim4_r};
        `OTFAC_OFS_RTIM5:  reg_rdata <= {5'h00, rtim5_r};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supply enables follow the supply register.
  assign logic_supply_en = supply_r[`OTFAC_SUP_LOGIC];
  assign prog_supply_en  = supply_r[`OTFAC_SUP_PROG];
  assign busy            = trig_r;

endmodule // otfac_ctrl

// ==== otfac_monitor.sv ====
// Checker of the fuse access controller port behaviour.
`timescale 1ns/1ps
module otfac_monitor #(
  parameter AW = 8
) (
  // Clock and reset.
  input wire          clk,
  input wire          resetn,
  // Host register port.
  input wire          reg_sel,
  input wire          reg_wr,
  input wire [7:0]    reg_addr,
  input wire [31:0]   reg_wdata,
  input wire          reg_unlock,
  // Fuse array and status.
  input wire [AW-1:0] fuse_addr,
  input wire          fuse_rd_en,
  input wire          fuse_strobe,
  input wire          fuse_pgm_en,
  input wire          fuse_pgm_pulse,
  input wire          logic_supply_en,
  input wire          prog_supply_en,
  input wire          busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // A host write of the trigger flag.
  sequence trig_req;
    reg_sel && reg_wr && reg_addr == 8'h1C && reg_wdata[1];
  endsequence
  supply_write_a: assert property (reg_sel && reg_wr && reg_addr == 8'h10 |=>
    logic_supply_en == $past(reg_wdata[0]) && prog_supply_en == $past(reg_wdata[1]))
    else $error("supply enables do not follow the written value");
  trig_start_a: assert property (trig_req ##0 (reg_unlock && !busy) |=> busy)
    else $error("unlocked trigger write did not start an operation");
  trig_locked_a: assert property (trig_req ##0 (!reg_unlock && !busy) |=> !busy)
    else $error("locked trigger write started an operation");
  strobe_in_read_a: assert property (fuse_strobe |-> fuse_rd_en && busy)
    else $error("read strobe outside an enabled read");
  pulse_in_pgm_a: assert property (fuse_pgm_pulse |-> fuse_pgm_en && busy)
    else $error("burn pulse outside program enable");
  idle_quiet_a: assert property (!busy |-> !fuse_rd_en && !fuse_pgm_en)
    else $error("fuse activity while no operation runs");
  addr_hold_a: assert property (busy && $past(busy) |-> $stable(fuse_addr))
    else $error("fuse address moved during an operation");
  no_overlap_a: assert property (!(fuse_rd_en && fuse_pgm_en))
    else $error("read and program enables high together");
endmodule // otfac_monitor

bind otfac_ctrl otfac_monitor #(.AW(AW)) u_mon (.clk(clk), .resetn(resetn),
  .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_unlock(reg_unlock), .fuse_addr(fuse_addr), .fuse_rd_en(fuse_rd_en),
  .fuse_strobe(fuse_strobe), .fuse_pgm_en(fuse_pgm_en), .fuse_pgm_pulse(fuse_pgm_pulse),
  .logic_supply_en(logic_supply_en), .prog_supply_en(prog_supply_en), .busy(busy));

// ==== otfac_fuse_model.sv ====
// Behavioural fuse array that answers reads and keeps blown bits.
`timescale 1ns/1ps
module otfac_fuse_model (
  // Fuse array pins.
  input  wire       clk,
  input  wire [7:0] fuse_addr,
  input  wire [2:0] fuse_bit,
  input  wire       fuse_rd_en,
  input  wire       fuse_pgm_pulse,
  output wire [7:0] fuse_rdata
);
  logic [7:0] mem [0:255];
  logic       pulse_q;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    pulse_q = 1'b0;
  end
  // A burn pulse blows one bit for good; nothing ever clears it.
  always @(posedge clk)
  begin
    pulse_q <= fuse_pgm_pulse;
    if (fuse_pgm_pulse && !pulse_q) mem[fuse_addr][fuse_bit] <= 1'b1;
  end
  // Outside a read the lines float, shown as the inverted byte.
  assign fuse_rdata = fuse_rd_en ? mem[fuse_addr] : ~mem[fuse_addr];
endmodule // otfac_fuse_model

// ==== tb_otfac_ctrl.sv ====
// Self-checking testbench of the fuse access controller.
`timescale 1ns/1ps
module tb_otfac_ctrl;
  logic        clk, resetn, reg_sel, reg_wr, reg_unlock;
  logic [7:0]  reg_addr, fuse_addr, fuse_rdata;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  fuse_bit;
  logic        fuse_rd_en, fuse_strobe, fuse_pgm_en, fuse_pgm_pulse;
  logic        logic_supply_en, prog_supply_en, busy;
  int          failures, n_checks, n_strobe, n_pulse, n_busy, n_rden;
  logic [39:0] tab [0:8] = '{40'h00_00000000, 40'h04_00000000, 40'h08_00000000,
    40'h10_00000001, 40'h18_00000002, 40'h1C_00000000, 40'h20_00104E06,
    40'h24_009C0884, 40'h40_00000000};
  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  otfac_ctrl dut (.clk(clk), .resetn(resetn), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_unlock(reg_unlock), .fuse_addr(fuse_addr), .fuse_bit(fuse_bit),
    .fuse_rd_en(fuse_rd_en), .fuse_strobe(fuse_strobe), .fuse_pgm_en(fuse_pgm_en),
    .fuse_pgm_pulse(fuse_pgm_pulse), .fuse_rdata(fuse_rdata),
    .logic_supply_en(logic_supply_en), .prog_supply_en(prog_supply_en), .busy(busy));
  otfac_fuse_model fuse (.clk(clk), .fuse_addr(fuse_addr), .fuse_bit(fuse_bit),
    .fuse_rd_en(fuse_rd_en), .fuse_pgm_pulse(fuse_pgm_pulse), .fuse_rdata(fuse_rdata));
  always @(posedge clk)
  begin
    if (fuse_strobe === 1'b1) n_strobe <= n_strobe + 1;
    if (fuse_pgm_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (busy === 1'b1) n_busy <= n_busy + 1;
    if (fuse_rd_en === 1'b1) n_rden <= n_rden + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_sel = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(reg_rdata, e);
  endtask
  task automatic run(input logic [31:0] cmd);
    int k;
    k = 0;
    acc(1'b1, 8'h18, cmd);
    n_strobe = 0;
    n_pulse = 0;
    n_busy = 0;
    n_rden = 0;
    acc(1'b1, 8'h1C, 32'h2);
    acc(1'b0, 8'h1C, 32'h0);
    while (reg_rdata[1] !== 1'b0 && k < 4000)
    begin
      acc(1'b0, 8'h1C, 32'h0);
      k++;
    end
    if (k == 4000) failures++;
  endtask
  task print_verdict;
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict;
  end
  initial
  begin
    clk = 0;
    resetn = 0;
    reg_sel = 0;
    reg_wr = 0;
    reg_unlock = 0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    failures = 0;
    n_checks = 0;
    n_strobe = 0;
    n_pulse = 0;
    n_busy = 0;
    n_rden = 0;
    repeat (16) @(posedge clk);
    #1 resetn = 1;
    foreach (tab[i]) rchk(tab[i][39:32], tab[i][31:0]);
    acc(1'b1, 8'h1C, 32'h2);
    rchk(8'h1C, 32'h0);
    acc(1'b1, 8'h00, 32'h1F);
    rchk(8'h00, 32'h0);
    reg_unlock = 1;
    acc(1'b1, 8'h00, 32'h1F);
    rchk(8'h00, 32'h1F);
    acc(1'b1, 8'h10, 32'h2);
    chk({30'h0, prog_supply_en, logic_supply_en}, 32'h2);
    acc(1'b1, 8'h10, 32'h3);
    acc(1'b1, 8'h04, 32'h45);
    acc(1'b1, 8'h08, 32'hA5);
    run(32'h1);
    chk({24'h0, fuse.mem[8'h45]}, 32'hA5);
    chk(n_pulse, 32'd528);
    chk(n_busy, 32'd804);
    acc(1'b1, 8'h10, 32'h1);
    chk({30'h0, prog_supply_en, logic_supply_en}, 32'h1);
    acc(1'b1, 8'h08, 32'h0);
    run(32'h0);
    rchk(8'h08, 32'hA5);
    chk(n_strobe, 32'd12);
    chk(n_rden, 32'd44);
    chk(n_busy, 32'd87);
    acc(1'b1, 8'h00, 32'h11F);
    acc(1'b1, 8'h2C, 32'h0014180F);
    run(32'h0);
    chk(n_strobe, 32'd5);
    chk(n_busy, 32'd80);
    acc(1'b1, 8'h00, 32'hFFF);
    acc(1'b1, 8'h28, 32'h00000427);
    acc(1'b1, 8'h2C, 32'h00140604);
    acc(1'b1, 8'h30, 32'h001C0209);
    acc(1'b1, 8'h08, 32'h0);
    run(32'h0);
    chk(n_strobe, 32'd5);
    chk(n_rden, 32'd18);
    chk(n_busy, 32'd38);
    rchk(8'h08, 32'hA5);
    acc(1'b1, 8'h04, 32'h85);
    acc(1'b1, 8'h00, 32'h17);
    run(32'h0);
    chk(n_strobe, 32'd0);
    acc(1'b1, 8'h00, 32'h1E);
    acc(1'b1, 8'h04, 32'h10);
    run(32'h0);
    chk(n_strobe, 32'd0);
    acc(1'b1, 8'h00, 32'h1F);
    run(32'h2);
    chk(n_strobe + n_pulse, 32'd0);
    acc(1'b1, 8'h24, 32'h009C08C6);
    rchk(8'h24, 32'h009C08C6);
    acc(1'b1, 8'h10, 32'h3);
    acc(1'b1, 8'h08, 32'h01);
    run(32'h1);
    chk({24'h0, fuse.mem[8'h10]}, 32'h01);
    chk(n_pulse, 32'd198);
    chk(n_busy, 32'd333);
    acc(1'b1, 8'h10, 32'h1);
    print_verdict;
  end
endmodule // tb_otfac_ctrl
